// ### design/cami_top.sv
// CAN acceptance masks and interrupt bookkeeping with APB register access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module cami_top
  import cami_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [CAMI_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cmp_valid_in,
  input wire logic [3:0] cmp_buf_in,
  input wire cami_frame_t rx_frame_in,
  input wire cami_frame_t buf_frame_in,
  output logic accept_valid_out,
  output logic accept_out,
  output logic [3:0] accept_buf_out,
  output cami_frame_t merged_frame_out,
  input wire logic [CAMI_NBUF-1:0] buf_done_in,
  input wire logic bus_error_in,
  input wire logic err_cnt_inc_in,
  input wire logic [2:0] node_state_in,
  output logic irq_out
);
  logic rst_meta;
  logic rst_n;
  logic [15:0] global_accept_mask_hi;
  logic [15:0] global_accept_mask_lo;
  logic [15:0] basic_accept_mask_hi;
  logic [15:0] basic_accept_mask_lo;
  logic [15:0] can_irq_enables;
  logic [15:0] can_irq_pending;
  logic [15:0] can_irq_code_enables;
  logic error_irq_type_select;
  logic [2:0] node_state_field;
  cami_code_t irq_code;
  cami_code_t next_irq_code;
  cami_mask_t global_accept_mask;
  cami_mask_t basic_accept_mask;
  logic g_match;
  logic b_match;
  cami_frame_t g_merged;
  cami_frame_t b_merged;
  logic setup_ph;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_mux;
  logic [15:0] clr_vec;
  logic [15:0] set_vec;
  logic ns_changed;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Halves joined into one 32-bit mask each
  always_comb begin
    global_accept_mask.rtr = global_accept_mask_hi[4];
    global_accept_mask.ide = global_accept_mask_hi[3];
    global_accept_mask.id = {global_accept_mask_hi[15:5], global_accept_mask_hi[2:0],
                             global_accept_mask_lo[15:1]};
    global_accept_mask.extended_remote_mask_bit = global_accept_mask_lo[0];
    basic_accept_mask.id = {basic_accept_mask_hi[15:5], basic_accept_mask_hi[2:0],
                            basic_accept_mask_lo[15:1]};
    basic_accept_mask.rtr = basic_accept_mask_hi[4];
    basic_accept_mask.ide = basic_accept_mask_hi[3];
    basic_accept_mask.extended_remote_mask_bit = basic_accept_mask_lo[0];
  end

  cami_mask_match u_global (
    .mask_in(global_accept_mask),
    .rx_in(rx_frame_in),
    .stored_in(buf_frame_in),
    .match_out(g_match),
    .merged_out(g_merged)
  );

  cami_mask_match u_basic (
    .mask_in(basic_accept_mask),
    .rx_in(rx_frame_in),
    .stored_in(buf_frame_in),
    .match_out(b_match),
    .merged_out(b_merged)
  );

  // Last buffer filters through the basic mask, the rest through the global one
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      accept_valid_out <= 1'b0;
      accept_out <= 1'b0;
      accept_buf_out <= 4'h0;
      merged_frame_out <= '0;
    end else begin
      accept_valid_out <= cmp_valid_in;
      if (cmp_valid_in) begin
        accept_buf_out <= cmp_buf_in;
        if (cmp_buf_in == CAMI_BASIC_BUF) begin
          accept_out <= b_match;
          merged_frame_out <= b_merged;
        end else begin
          accept_out <= g_match;
          merged_frame_out <= g_merged;
        end
      end else begin
        accept_out <= 1'b0;
      end
    end
  end

  // APB: no wait state, answer registered at the setup edge
  assign setup_ph = psel_in && !penable_in && !pready_out;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr_in)
      CAMI_GM_HI: rd_mux[15:0] = global_accept_mask_hi;
      CAMI_GM_LO: rd_mux[15:0] = global_accept_mask_lo;
      CAMI_BM_HI: rd_mux[15:0] = basic_accept_mask_hi;
      CAMI_BM_LO: rd_mux[15:0] = basic_accept_mask_lo;
      CAMI_IEN: rd_mux[15:0] = can_irq_enables;
      CAMI_PND: rd_mux[15:0] = can_irq_pending;
      CAMI_CLR: rd_mux[15:0] = CAMI_RST16;
      CAMI_CEN: rd_mux[15:0] = can_irq_code_enables;
      CAMI_STPND: begin
        rd_mux[CAMI_NS_MSB:CAMI_NS_LSB] = node_state_field;
        rd_mux[CAMI_IRQ_BIT:0] = irq_code;
      end
      CAMI_CFG: rd_mux[CAMI_CFG_EIT_BIT] = error_irq_type_select;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= setup_ph;
      pslverr_out <= setup_ph && !mapped;
      if (setup_ph && !pwrite_in) begin
        prdata_out <= rd_mux;
      end
    end
  end

  // Writable control words
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      global_accept_mask_hi <= CAMI_RST16;
      global_accept_mask_lo <= CAMI_RST16;
      basic_accept_mask_hi <= CAMI_RST16;
      basic_accept_mask_lo <= CAMI_RST16;
      can_irq_enables <= CAMI_RST16;
      can_irq_code_enables <= CAMI_RST16;
      error_irq_type_select <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr_in)
        CAMI_GM_HI: global_accept_mask_hi <= pwdata_in[15:0];
        CAMI_GM_LO: global_accept_mask_lo <= pwdata_in[15:0];
        CAMI_BM_HI: basic_accept_mask_hi <= pwdata_in[15:0];
        CAMI_BM_LO: basic_accept_mask_lo <= pwdata_in[15:0];
        CAMI_IEN: can_irq_enables <= pwdata_in[15:0];
        CAMI_CEN: can_irq_code_enables <= pwdata_in[15:0];
        CAMI_CFG: error_irq_type_select <= pwdata_in[CAMI_CFG_EIT_BIT];
        default: ;
      endcase
    end
  end

  // Node status follows the error counter logic
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      node_state_field <= CAMI_NS_OFF;
    end else begin
      node_state_field <= node_state_in;
    end
  end

  assign ns_changed = err_cnt_inc_in && (node_state_in != node_state_field);

  // Clear word is a plain write of ones; reads of it return zero
  assign clr_vec = (wr_en && paddr_in == CAMI_CLR) ? pwdata_in[15:0] : CAMI_RST16;

  always_comb begin
    set_vec = {1'b0, buf_done_in};
    set_vec[CAMI_ERR_BIT] = error_irq_type_select ? ns_changed : bus_error_in;
  end

  // A set arriving with its clear wins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      can_irq_pending <= CAMI_RST16;
    end else begin
      can_irq_pending <= (can_irq_pending & ~clr_vec) | set_vec;
    end
  end

  cami_prio_enc u_prio (
    .req_in(can_irq_pending & can_irq_code_enables),
    .code_out(next_irq_code)
  );

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_code <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_code <= next_irq_code;
      irq_out <= |(can_irq_pending & can_irq_enables);
    end
  end

  apb_ready_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    setup_ph |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle after setup");

  reject_cared_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in && rx_frame_in.ide && cmp_buf_in != CAMI_BASIC_BUF &&
    ((rx_frame_in.id ^ buf_frame_in.id) & ~global_accept_mask.id) != 29'h0
    |=> accept_valid_out && !accept_out)
    else $error("frame accepted despite cared identifier mismatch");

  merge_id_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in && rx_frame_in.ide && cmp_buf_in != CAMI_BASIC_BUF
    |=> merged_frame_out.id == (($past(rx_frame_in.id) & $past(global_accept_mask.id)) |
        ($past(buf_frame_in.id) & ~$past(global_accept_mask.id))))
    else $error("merged identifier wrong");

  std_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in && !rx_frame_in.ide && cmp_buf_in == CAMI_BASIC_BUF &&
    ((rx_frame_in.id[28:18] ^ buf_frame_in.id[28:18]) & ~basic_accept_mask.id[28:18]) == 11'h0 &&
    (basic_accept_mask.rtr || rx_frame_in.rtr == buf_frame_in.rtr) &&
    (basic_accept_mask.ide || rx_frame_in.ide == buf_frame_in.ide)
    |=> accept_out)
    else $error("standard frame rejected on unused bits");

  buf_set_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    buf_done_in != 15'h0 |=> (can_irq_pending[14:0] & $past(buf_done_in)) == $past(buf_done_in))
    else $error("buffer pending not set");

  err_type_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !error_irq_type_select && bus_error_in |=> can_irq_pending[CAMI_ERR_BIT])
    else $error("error pending not set on bus error");

  clear_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_en && paddr_in == CAMI_CLR && pwdata_in[0] && !buf_done_in[0]
    |=> !can_irq_pending[0])
    else $error("write one did not clear pending");

  code_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (can_irq_pending & can_irq_code_enables) == 16'h0 |=> irq_code == '0)
    else $error("disabled source shows in code");

  irq_err_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !can_irq_enables[CAMI_ERR_BIT] && (can_irq_pending[14:0] & can_irq_enables[14:0]) == 15'h0
    |=> !irq_out)
    else $error("interrupt raised with no enabled source");

  err_first_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    can_irq_pending[CAMI_ERR_BIT] && can_irq_code_enables[CAMI_ERR_BIT]
    |=> irq_code.irq && irq_code.irq_source_code == CAMI_IST_NONE)
    else $error("error source not ranked first");

  // Bus side
  apb_err_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    setup_ph && !mapped |=> pready_out && pslverr_out)
    else $error("unmapped address answered without slave error");

  clr_reads_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    setup_ph && !pwrite_in && paddr_in == CAMI_CLR |=> prdata_out == 32'h00000000)
    else $error("clear word read back nonzero");

  pnd_readonly_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_en && paddr_in == CAMI_PND && set_vec == 16'h0000 |=> $stable(can_irq_pending))
    else $error("write to pending word changed it");

  // Pending flags
  err_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    can_irq_pending[CAMI_ERR_BIT] && !clr_vec[CAMI_ERR_BIT] |=> can_irq_pending[CAMI_ERR_BIT])
    else $error("error pending dropped without clear");

  err_state_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    error_irq_type_select && err_cnt_inc_in && node_state_in != node_state_field
    |=> can_irq_pending[CAMI_ERR_BIT])
    else $error("error pending not set on node status change");

  err_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    error_irq_type_select && !err_cnt_inc_in && !can_irq_pending[CAMI_ERR_BIT]
    |=> !can_irq_pending[CAMI_ERR_BIT])
    else $error("error pending set without node status change");

  clear_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_en && paddr_in == CAMI_CLR
    |=> ((can_irq_pending ^ $past(can_irq_pending)) & ~$past(pwdata_in[15:0]) &
        ~$past(set_vec)) == 16'h0000)
    else $error("zero in clear word changed a flag");

  // Request and code
  irq_on_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (can_irq_pending & can_irq_enables) != 16'h0000 |=> irq_out)
    else $error("interrupt missing with enabled pending source");

  code_buf0_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !(can_irq_pending[CAMI_ERR_BIT] && can_irq_code_enables[CAMI_ERR_BIT]) &&
    can_irq_pending[0] && can_irq_code_enables[0]
    |=> irq_code.irq && irq_code.irq_source_code == 4'h1)
    else $error("buffer zero code wrong");

  // Acceptance outputs
  accept_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !cmp_valid_in |=> !accept_valid_out && !accept_out)
    else $error("acceptance shown without a compare");

  accept_buf_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in |=> accept_valid_out && accept_buf_out == $past(cmp_buf_in))
    else $error("acceptance buffer number wrong");

  std_rtr_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in && !rx_frame_in.ide && cmp_buf_in != CAMI_BASIC_BUF &&
    !global_accept_mask.rtr && rx_frame_in.rtr != buf_frame_in.rtr
    |=> !accept_out)
    else $error("standard frame accepted despite cared remote bit");

  ext_srr_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmp_valid_in && rx_frame_in.ide && cmp_buf_in != CAMI_BASIC_BUF &&
    !global_accept_mask.rtr && rx_frame_in.srr != buf_frame_in.srr
    |=> !accept_out)
    else $error("extended frame accepted despite cared SRR bit");
endmodule : cami_top

// ### design/cami_pkg.sv
// Constants, types and register map for CAN acceptance masking and interrupt bookkeeping
// Function
// - Mask bit 0: incoming bit must match buffer
// - Mask bit 1: don't care, stored bit overwritten
// - Extended frames use all global mask bits
// - Standard frames use mask 28..18, RTR, IDE
// - Basic mask acts likewise for extended frames
// - Basic mask standard frames use 28..18, RTR, IDE
// - Basic mask halves layout, reset zero, read/write
// - Enable word: error bit 15, buffers 14:0
// - Error interrupt only when error enable set
// - Buffer pending set on successful transfer
// - Error pending sticks until software clears
// - Clear word: write one clears, zero keeps
// - Code enables select sources for encoded code
// - Node status field in bits 7:5
// - Request bit and source field encoding
// - Error type selects every error or state change
package cami_pkg;
  localparam int CAMI_AW = 8;
  localparam int CAMI_NBUF = 15;
  localparam logic [3:0] CAMI_BASIC_BUF = 4'he;
  // Register byte offsets
  localparam logic [CAMI_AW-1:0] CAMI_GM_HI = 8'h00;
  localparam logic [CAMI_AW-1:0] CAMI_GM_LO = 8'h04;
  localparam logic [CAMI_AW-1:0] CAMI_BM_HI = 8'h08;
  localparam logic [CAMI_AW-1:0] CAMI_BM_LO = 8'h0c;
  localparam logic [CAMI_AW-1:0] CAMI_IEN = 8'h10;
  localparam logic [CAMI_AW-1:0] CAMI_PND = 8'h14;
  localparam logic [CAMI_AW-1:0] CAMI_CLR = 8'h18;
  localparam logic [CAMI_AW-1:0] CAMI_CEN = 8'h1c;
  localparam logic [CAMI_AW-1:0] CAMI_STPND = 8'h20;
  localparam logic [CAMI_AW-1:0] CAMI_CFG = 8'h24;
  localparam logic [15:0] CAMI_RST16 = 16'h0000;
  // Word field positions
  localparam int CAMI_ERR_BIT = 15;
  localparam int CAMI_CFG_EIT_BIT = 0;
  localparam int CAMI_NS_LSB = 5;
  localparam int CAMI_NS_MSB = 7;
  localparam int CAMI_IRQ_BIT = 4;
  // Node status codes
  localparam logic [2:0] CAMI_NS_OFF = 3'h0;
  localparam logic [2:0] CAMI_NS_ACTIVE = 3'h2;
  localparam logic [2:0] CAMI_NS_WARN = 3'h3;
  localparam logic [2:0] CAMI_NS_PASSIVE = 3'h4;
  localparam logic [2:0] CAMI_NS_BUSOFF = 3'h6;
  localparam logic [3:0] CAMI_IST_NONE = 4'h0;
  // Standard identifiers travel left-aligned in id[28:18]
  typedef struct packed {
    logic [28:0] id;
    logic srr;
    logic ide;
    logic rtr;
  } cami_frame_t;
  typedef struct packed {
    logic [28:0] id;
    logic rtr;
    logic ide;
    logic extended_remote_mask_bit;
  } cami_mask_t;
  typedef struct packed {
    logic irq;
    logic [3:0] irq_source_code;
  } cami_code_t;
endpackage : cami_pkg

// ### design/cami_mask_match.sv
// One acceptance mask comparator with identifier merge
`timescale 1ns/1ps
module cami_mask_match
  import cami_pkg::*;
(
  input wire cami_mask_t mask_in,
  input wire cami_frame_t rx_in,
  input wire cami_frame_t stored_in,
  output logic match_out,
  output cami_frame_t merged_out
);
  logic [31:0] rx_v;
  logic [31:0] st_v;
  logic [31:0] dc_v;
  logic [31:0] used_v;

  always_comb begin
    rx_v = rx_in;
    st_v = stored_in;
    // Mask RTR guards SRR, extended-remote bit guards RTR
    dc_v = {mask_in.id, mask_in.rtr, mask_in.ide, mask_in.extended_remote_mask_bit};
    if (rx_in.ide) begin
      used_v = 32'hffffffff;
    end else begin
      // Standard: id 28..18 vs mask 28..18, RTR against mask RTR, IDE
      used_v = {11'h7ff, 18'h00000, 3'h0};
      dc_v[0] = mask_in.rtr;
      dc_v[1] = mask_in.ide;
      used_v[1] = 1'b1;
      used_v[0] = 1'b1;
    end
    match_out = ((rx_v ^ st_v) & used_v & ~dc_v) == 32'h00000000;
    merged_out = (st_v & ~(dc_v & used_v)) | (rx_v & dc_v & used_v);
  end
endmodule : cami_mask_match

// ### design/cami_prio_enc.sv
// Highest priority pending source encoder
`timescale 1ns/1ps
module cami_prio_enc
  import cami_pkg::*;
(
  input wire logic [15:0] req_in,
  output cami_code_t code_out
);
  always_comb begin
    code_out = '{irq: 1'b0, irq_source_code: CAMI_IST_NONE};
    // Walk downward so the lowest buffer wins
    for (int i = CAMI_NBUF - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        code_out = '{irq: 1'b1, irq_source_code: 4'(i + 1)};
      end
    end
    if (req_in[CAMI_ERR_BIT]) begin
      code_out = '{irq: 1'b1, irq_source_code: CAMI_IST_NONE};
    end
  end
endmodule : cami_prio_enc

// ### sim/cami_rx_model.sv
// Far-side model: frame receiver, buffer compare strobes and error counter events
`timescale 1ns/1ps
module cami_rx_model
  import cami_pkg::*;
(
  input wire logic clk_in,
  output logic cmp_valid_out,
  output logic [3:0] cmp_buf_out,
  output cami_frame_t rx_frame_out,
  output cami_frame_t buf_frame_out,
  output logic [CAMI_NBUF-1:0] buf_done_out,
  output logic bus_error_out,
  output logic err_cnt_inc_out,
  output logic [2:0] node_state_out
);
  initial begin
    cmp_valid_out = 1'b0;
    cmp_buf_out = 4'h0;
    rx_frame_out = '0;
    buf_frame_out = '0;
    buf_done_out = '0;
    bus_error_out = 1'b0;
    err_cnt_inc_out = 1'b0;
    node_state_out = 3'h0;
  end
  // Frame lines scrambled after the strobe so stale values never pass
  task send(input logic [3:0] b, input cami_frame_t rx, input cami_frame_t st);
    @(posedge clk_in);
    cmp_valid_out <= 1'b1;
    cmp_buf_out <= b;
    rx_frame_out <= rx;
    buf_frame_out <= st;
    @(posedge clk_in);
    cmp_valid_out <= 1'b0;
    rx_frame_out <= ~rx;
    buf_frame_out <= ~st;
  endtask : send
  // Node state is a level and stays; the rest are one-cycle pulses
  task pulse(input logic [14:0] d, input logic be, input logic inc, input logic [2:0] s);
    @(posedge clk_in);
    buf_done_out <= d;
    bus_error_out <= be;
    err_cnt_inc_out <= inc;
    node_state_out <= s;
    @(posedge clk_in);
    buf_done_out <= '0;
    bus_error_out <= 1'b0;
    err_cnt_inc_out <= 1'b0;
  endtask : pulse
endmodule : cami_rx_model

// ### sim/cami_tb_top.sv
// Self-checking bench for acceptance masks and interrupt bookkeeping
`timescale 1ns/1ps
module cami_tb_top;
  import cami_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, acc_v, acc, irq, cv, be, inc;
  logic [3:0] acc_buf, cb;
  logic [14:0] done;
  logic [2:0] ns;
  cami_frame_t merged, rxf, stf;
  logic [2:0] states [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  cami_top DUT (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cmp_valid_in(cv), .cmp_buf_in(cb),
    .rx_frame_in(rxf), .buf_frame_in(stf), .accept_valid_out(acc_v), .accept_out(acc),
    .accept_buf_out(acc_buf), .merged_frame_out(merged), .buf_done_in(done),
    .bus_error_in(be), .err_cnt_inc_in(inc), .node_state_in(ns), .irq_out(irq));
  cami_rx_model model (.clk_in(clk_in), .cmp_valid_out(cv), .cmp_buf_out(cb),
    .rx_frame_out(rxf), .buf_frame_out(stf), .buf_done_out(done), .bus_error_out(be),
    .err_cnt_inc_out(inc), .node_state_out(ns));
  task close_out;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task irq_chk(input logic exp);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irq_chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rdv);
  endtask : rd
  // Mode bit0 expects acceptance, bit1 also expects merged equal to received
  task cmp(input logic [3:0] b, input cami_frame_t rx, input cami_frame_t st,
    input logic [1:0] m);
    model.send(b, rx, st);
    @(negedge clk_in);
    chk("accept valid", 32'h1, {31'h0, acc_v});
    chk("accept", {31'h0, m[0]}, {31'h0, acc});
    chk("accept buffer", {28'h0, b}, {28'h0, acc_buf});
    if (m[1]) chk("merged", rx, merged);
  endtask : cmp
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0);
    foreach (states[i]) begin
      wr(8'(8 + 4 * (i % 3) + (i == 3 ? 20 : 0)), 32'hffff_a5c3);
      rd(8'(8 + 4 * (i % 3) + (i == 3 ? 20 : 0)), 32'h0000_a5c3);
      wr(8'(8 + 4 * (i % 3) + (i == 3 ? 20 : 0)), 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("slave error", 32'h1, {31'h0, errv});
    cmp(4'h2, 32'h1200_0000, 32'h1200_0000, 2'b11);
    cmp(4'h2, 32'h1220_0000, 32'h1200_0000, 2'b00);
    cmp(4'h2, 32'h1200_0008, 32'h1200_0000, 2'b01);
    cmp(4'h2, 32'h1200_000a, 32'h1200_0002, 2'b00);
    cmp(4'h2, 32'h1200_0006, 32'h1200_0002, 2'b00);
    cmp(4'h2, 32'h1200_0001, 32'h1200_0000, 2'b00);
    wr(CAMI_GM_HI, 32'h0030);
    wr(CAMI_GM_LO, 32'h0001);
    cmp(4'h5, 32'h1220_0000, 32'h1200_0000, 2'b11);
    cmp(4'h5, 32'h1200_0001, 32'h1200_0000, 2'b11);
    cmp(4'h5, 32'h1200_0003, 32'h1200_0002, 2'b11);
    cmp(4'h5, 32'h1200_0006, 32'h1200_0002, 2'b11);
    cmp(4'he, 32'h1220_0000, 32'h1200_0000, 2'b00);
    wr(CAMI_BM_HI, 32'h8000);
    cmp(4'he, 32'h9200_0002, 32'h1200_0002, 2'b11);
    cmp(4'h3, 32'h9200_0002, 32'h1200_0002, 2'b00);
    wr(CAMI_CEN, 32'hffff);
    wr(CAMI_IEN, 32'hffff);
    model.pulse(15'h0208, 1'b0, 1'b0, 3'h0);
    rd(CAMI_PND, 32'h0208);
    rd(CAMI_STPND, 32'h14);
    irq_chk(1'b1);
    wr(CAMI_CLR, 32'h0008);
    rd(CAMI_PND, 32'h0200);
    rd(CAMI_STPND, 32'h1a);
    wr(CAMI_PND, 32'hffff);
    rd(CAMI_PND, 32'h0200);
    wr(CAMI_CEN, 32'hfdff);
    rd(CAMI_STPND, 32'h00);
    irq_chk(1'b1);
    wr(CAMI_IEN, 32'h0);
    rd(CAMI_STPND, 32'h00);
    irq_chk(1'b0);
    wr(CAMI_CLR, 32'h0200);
    wr(CAMI_IEN, 32'hffff);
    wr(CAMI_CEN, 32'hffff);
    for (int n = 0; n < 15; n++) begin
      model.pulse(15'(1 << n), 1'b0, 1'b0, 3'h0);
      rd(CAMI_STPND, 32'(n + 17));
      wr(CAMI_CLR, 32'(1) << n);
    end
    model.pulse(15'h0001, 1'b1, 1'b0, 3'h0);
    rd(CAMI_PND, 32'h8001);
    rd(CAMI_STPND, 32'h10);
    irq_chk(1'b1);
    wr(CAMI_IEN, 32'h7ffe);
    wr(CAMI_CLR, 32'h0);
    irq_chk(1'b0);
    rd(CAMI_PND, 32'h8001);
    wr(CAMI_CLR, 32'h8001);
    rd(CAMI_PND, 32'h0);
    wr(CAMI_CFG, 32'h1);
    model.pulse(15'h0, 1'b1, 1'b0, 3'h0);
    rd(CAMI_PND, 32'h0);
    model.pulse(15'h0, 1'b0, 1'b1, 3'h2);
    rd(CAMI_PND, 32'h8000);
    rd(CAMI_STPND, 32'h50);
    wr(CAMI_CLR, 32'h8000);
    foreach (states[i]) begin
      model.pulse(15'h0, 1'b0, 1'b0, states[i]);
      rd(CAMI_STPND, {24'h0, states[i], 5'h0});
    end
    close_out();
  end
endmodule : cami_tb_top
